// ---- verilog/idle_power_gate.sv ----
// Idle mode sequencer and per-peripheral power gate, with APB registers.
// Assumes clk at 25 MHz, an APB master, and a Timer1 oscillator status pin.
//
// Overview of operation
// - Idle sleep stops CPU, peripherals keep clocking
// - Idle entry leaves clock status bits alone
// - Keep RC for watchdog, Timer1 if enabled
// - Exit idle only on interrupt, watchdog, reset
// - Hold CPU off for wake-ready delay
// - Resume CPU on idle clock source
// - Wake never alters idle select or source
// - Watchdog wake goes to selected run mode
// - Primary idle keeps primary clock, status set
// - Timer1 switch stops primary, updates status flags
// - Secondary idle wake stays on Timer1
// - Secondary sleep ignored if Timer1 oscillator disabled
// - Withhold peripheral clock until Timer1 starts
// - Each peripheral has a set-to-disable bit
// - Set bit removes power, clocks, register access
// - Enable bit seven keeps peripheral reconfigurable
// - Unimplemented off bits read as zero
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "power_gate_cfg.svh"
module idle_power_gate (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // CPU core events
   input wire logic sleep_exec,
   input wire logic irq_wake,
   input wire logic wdt_timeout,
   // Oscillator status pin
   input wire logic timer1_osc_ok_pin,
   // Clock gates
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic [1:0] periph_src,
   output logic primary_osc_on,
   output logic timer1_osc_on,
   output logic internal_rc_on,
   // Per-module power, one bit per module off bit
   output logic [31:0] module_power_on
);
   // ==========================================================
   // Register state
   logic [7:0] capture_module_off_bits_c;
   logic [7:0] timer_comparator_off_bits;
   logic [7:0] timer_misc_off_bits;
   logic [7:0] serial_converter_off_bits;
   logic [1:0] system_clock_select;
   logic idle_on_sleep_select;
   logic timer1_osc_enable;
   logic wdt_enable;
   logic primary_osc_startup_status;
   logic secondary_osc_running_flag;
   logic [1:0] key_stage;
   power_gate_pkg::power_state_t state;
   logic [3:0] wake_cnt;
   logic t1_running;

   logic wr_en;
   logic rd_en;
   logic [7:0] wbyte;

   // Decoded access phase
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign wbyte = pwdata[7:0];

   // Known address check, used for the error response only
   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == `OFF_CAPTURE_OFF) || (a == `OFF_TIMER_CMP_OFF) ||
         (a == `OFF_TIMER_MISC_OFF) || (a == `OFF_SERIAL_OFF) ||
         (a == `OFF_CLOCK_CTRL) || (a == `OFF_UNLOCK_KEY) ||
         (a == `OFF_CLOCK_STATUS);
   endfunction

   // Timer1 oscillator health from its pin
   pin_sync3 u_t1_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .pin(timer1_osc_ok_pin),
      .level(t1_running)
   );

   // ==========================================================
   // APB handshake: one wait-free access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_known(paddr);
      end
   end

   // Read data is prepared in the setup cycle so it stands with pready
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `OFF_CAPTURE_OFF: prdata[7:0] <= capture_module_off_bits_c;
            `OFF_TIMER_CMP_OFF: prdata[7:0] <= timer_comparator_off_bits;
            `OFF_TIMER_MISC_OFF: prdata[7:0] <= timer_misc_off_bits;
            `OFF_SERIAL_OFF: prdata[7:0] <= serial_converter_off_bits;
            `OFF_CLOCK_CTRL: prdata[4:0] <= {wdt_enable, timer1_osc_enable,
               idle_on_sleep_select, system_clock_select};
            `OFF_CLOCK_STATUS: prdata[3:0] <= {cpu_clk_en, t1_running,
               secondary_osc_running_flag, primary_osc_startup_status};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Module off registers; all clear at reset
   // write 1 disables module
   always_ff @(posedge clk) begin
      if (rst) begin
         capture_module_off_bits_c <= `RESET_MODULE_OFF;
         timer_comparator_off_bits <= `RESET_MODULE_OFF;
         timer_misc_off_bits <= `RESET_MODULE_OFF;
         serial_converter_off_bits <= `RESET_MODULE_OFF;
      end else if (ce && wr_en) begin
         case (paddr)
            `OFF_CAPTURE_OFF: capture_module_off_bits_c <= wbyte & `MASK_CAPTURE_OFF;
            `OFF_TIMER_CMP_OFF: timer_comparator_off_bits <= wbyte & `MASK_TIMER_CMP_OFF;
            // rtc bit only changes after the key
            `OFF_TIMER_MISC_OFF: begin
               timer_misc_off_bits <= wbyte & `MASK_TIMER_MISC_OFF;
               if (key_stage != 2'h2) begin
                  timer_misc_off_bits[`RTC_OFF_BIT] <= timer_misc_off_bits[`RTC_OFF_BIT];
               end
            end
            `OFF_SERIAL_OFF: serial_converter_off_bits <= wbyte & `MASK_SERIAL_OFF;
            default: ;
         endcase
      end
   end

   // Unlock key: 55h then AAh arms the next write only
   // key sequence tracking
   always_ff @(posedge clk) begin
      if (rst) begin
         key_stage <= 2'h0;
      end else if (ce && wr_en) begin
         if (paddr == `OFF_UNLOCK_KEY && wbyte == `UNLOCK_KEY_FIRST) begin
            key_stage <= 2'h1;
         end else if (paddr == `OFF_UNLOCK_KEY && wbyte == `UNLOCK_KEY_SECOND
               && key_stage == 2'h1) begin
            key_stage <= 2'h2;
         end else begin
            key_stage <= 2'h0;
         end
      end
   end

   // ==========================================================
   // Clock control register; hardware never writes it on wake
   // only software changes select fields
   always_ff @(posedge clk) begin
      if (rst) begin
         system_clock_select <= 2'h0;
         idle_on_sleep_select <= 1'b0;
         timer1_osc_enable <= 1'b0;
         wdt_enable <= 1'b0;
      end else if (ce && wr_en && paddr == `OFF_CLOCK_CTRL) begin
         system_clock_select <= wbyte[`CTRL_SCS_LSB +: 2];
         idle_on_sleep_select <= wbyte[`CTRL_IDLE_BIT];
         timer1_osc_enable <= wbyte[`CTRL_T1EN_BIT];
         wdt_enable <= wbyte[`CTRL_WDT_BIT];
      end
   end

   // Clock source status follows the selected source, not the power state
   // idle entry does not touch status
   // Timer1 source clears startup, sets running
   // startup status stays set on primary
   always_ff @(posedge clk) begin
      if (rst) begin
         primary_osc_startup_status <= 1'b1;
         secondary_osc_running_flag <= 1'b0;
      end else if (ce) begin
         primary_osc_startup_status <=
            system_clock_select == power_gate_pkg::SRC_PRIMARY;
         secondary_osc_running_flag <=
            system_clock_select == power_gate_pkg::SRC_SECONDARY;
      end
   end

   // ==========================================================
   // Power state sequencer
   logic sleep_ok;
   logic wake_evt;
   assign sleep_ok = idle_on_sleep_select &&
      !(system_clock_select == power_gate_pkg::SRC_SECONDARY && !timer1_osc_enable);
   // only interrupt or watchdog wake; reset is rst
   assign wake_evt = irq_wake || (wdt_timeout && wdt_enable);

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= power_gate_pkg::ST_RUN;
         wake_cnt <= 4'h0;
      end else if (ce) begin
         case (state)
            power_gate_pkg::ST_RUN: begin
               if (sleep_exec && sleep_ok) begin
                  state <= power_gate_pkg::ST_IDLE;
               end
            end
            power_gate_pkg::ST_IDLE: begin
               // wake into run mode of current select
               if (wake_evt) begin
                  state <= power_gate_pkg::ST_WAKE;
                  wake_cnt <= 4'(`WAKE_DELAY_CYCLES - 1);
               end
            end
            power_gate_pkg::ST_WAKE: begin
               if (wake_cnt == 4'h0) begin
                  state <= power_gate_pkg::ST_RUN;
               end else begin
                  wake_cnt <= wake_cnt - 4'h1;
               end
            end
            default: state <= power_gate_pkg::ST_RUN;
         endcase
      end
   end

   // ==========================================================
   // Clock gate outputs, all registered
   // CPU gated off outside run
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         periph_src <= 2'h0;
      end else if (ce) begin
         cpu_clk_en <= state == power_gate_pkg::ST_RUN &&
            !(sleep_exec && sleep_ok);
         periph_clk_en <= system_clock_select != power_gate_pkg::SRC_SECONDARY
            || t1_running;
         periph_src <= system_clock_select;
      end
   end

   // Oscillator enables
   // RC for watchdog, Timer1 when enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         primary_osc_on <= 1'b1;
         timer1_osc_on <= 1'b0;
         internal_rc_on <= 1'b0;
      end else if (ce) begin
         primary_osc_on <= system_clock_select == power_gate_pkg::SRC_PRIMARY;
         timer1_osc_on <= timer1_osc_enable ||
            system_clock_select == power_gate_pkg::SRC_SECONDARY;
         internal_rc_on <= wdt_enable || system_clock_select[1];
      end
   end

   // Module power; enable bit seven lives in the peripheral, untouched here
   // set off bit removes power and clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         module_power_on <= 32'hFFFF_FFFF;
      end else if (ce) begin
         module_power_on <= ~{capture_module_off_bits_c, timer_comparator_off_bits,
            timer_misc_off_bits, serial_converter_off_bits};
      end
   end

   // ==========================================================
   // Checks
   sequence s_wake_seen;
      state == power_gate_pkg::ST_IDLE && wake_evt && ce;
   endsequence

   chk_wake_delay_run: assert property (@(posedge clk) disable iff (rst)
      s_wake_seen ##1 (state == power_gate_pkg::ST_WAKE && ce) [*5]
      |=> state == power_gate_pkg::ST_RUN)
      else $error("wake delay not honoured");

   chk_idle_holds: assert property (@(posedge clk) disable iff (rst)
      state == power_gate_pkg::ST_IDLE && !wake_evt |=> state == power_gate_pkg::ST_IDLE)
      else $error("idle left without wake");

   chk_cpu_off_idle: assert property (@(posedge clk) disable iff (rst)
      ce && state == power_gate_pkg::ST_IDLE ##1 ce |-> !cpu_clk_en)
      else $error("cpu clocked during idle");

   chk_sleep_ignored: assert property (@(posedge clk) disable iff (rst)
      ce && state == power_gate_pkg::ST_RUN && sleep_exec && !timer1_osc_enable &&
      system_clock_select == power_gate_pkg::SRC_SECONDARY |=> state == power_gate_pkg::ST_RUN)
      else $error("secondary idle entered without Timer1");

   chk_wake_keeps_sel: assert property (@(posedge clk) disable iff (rst)
      (s_wake_seen and !wr_en) |=> $stable(system_clock_select) && $stable(idle_on_sleep_select))
      else $error("wake changed select bits");

   chk_off_removes_pwr: assert property (@(posedge clk) disable iff (rst)
      ce && serial_converter_off_bits[0] |=> !module_power_on[0])
      else $error("disabled module still powered");

   chk_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
      capture_module_off_bits_c[0] == 1'b0 && timer_comparator_off_bits[7] == 1'b0 &&
      timer_comparator_off_bits[5] == 1'b0 && timer_misc_off_bits[0] == 1'b0)
      else $error("unimplemented off bit set");

   chk_rtc_locked: assert property (@(posedge clk) disable iff (rst)
      ce && key_stage != 2'h2 |=> $stable(timer_misc_off_bits[`RTC_OFF_BIT]))
      else $error("rtc off bit changed without key");
endmodule // idle_power_gate
`default_nettype wire

// ---- include/power_gate_cfg.svh ----
// Constants for the idle mode and module power gate block.
// Assumes a 25 MHz system clock and an APB register port.
`ifndef POWER_GATE_CFG_SVH
`define POWER_GATE_CFG_SVH

// Register byte addresses
`define OFF_CAPTURE_OFF     12'h000
`define OFF_TIMER_CMP_OFF   12'h004
`define OFF_TIMER_MISC_OFF  12'h008
`define OFF_SERIAL_OFF      12'h00C
`define OFF_CLOCK_CTRL      12'h010
`define OFF_UNLOCK_KEY      12'h014
`define OFF_CLOCK_STATUS    12'h018

// Implemented bit masks of the module off registers
`define MASK_CAPTURE_OFF    8'hFE
`define MASK_TIMER_CMP_OFF  8'h5F
`define MASK_TIMER_MISC_OFF 8'hFE
`define MASK_SERIAL_OFF     8'hFF
`define RESET_MODULE_OFF    8'h00

// Position of the real-time clock off bit in the misc register
`define RTC_OFF_BIT         5

// Clock control field positions
`define CTRL_SCS_LSB        0
`define CTRL_IDLE_BIT       2
`define CTRL_T1EN_BIT       3
`define CTRL_WDT_BIT        4

// Unlock key values
`define UNLOCK_KEY_FIRST    8'h55
`define UNLOCK_KEY_SECOND   8'hAA

// Wake-ready delay
`define WAKE_DELAY_NS       200
`define CLK_PERIOD_NS       40
`define WAKE_DELAY_CYCLES   ((`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- include/power_gate_pkg.sv ----
// Types for the idle mode and module power gate block.
// Assumes nothing of its surroundings.
package power_gate_pkg;
   // Clock source selections
   typedef enum logic [1:0] {
      SRC_PRIMARY = 2'h0,
      SRC_SECONDARY = 2'h1,
      SRC_INTERNAL = 2'h2,
      SRC_INTERNAL_ALT = 2'h3
   } clk_src_t;

   // CPU power states
   typedef enum logic [1:0] {
      ST_RUN,
      ST_IDLE,
      ST_WAKE
   } power_state_t;
endpackage

// ---- verilog/pin_sync3.sv ----
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Pin and result
   input wire logic pin,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;

   // Level changes only once the last two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
      end else if (ce) begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end
endmodule // pin_sync3
`default_nettype wire

// ---- test/t1_osc_model.sv ----
// Timer1 oscillator model: reports oscillation a set time after enable.
// Assumes the bench clock; the status pin is low while the crystal is off.
`timescale 1ns/100ps
`default_nettype none
module t1_osc_model (
   // Clock
   input wire logic clk,
   // Oscillator control
   input wire logic enable,
   input wire logic [7:0] start_cycles,
   // Status pin
   output logic ok_pin
);
   logic [7:0] count;
   // ==========================================
   // Start-up counter
   // A crystal needs time to build up, so a slow start can be asked for
   always_ff @(posedge clk) begin
      if (!enable) begin
         count <= 8'h00;
         ok_pin <= 1'b0;
      end else if (count >= start_cycles) begin
         ok_pin <= 1'b1;
      end else begin
         count <= count + 8'h01;
      end
   end
endmodule // t1_osc_model
`default_nettype wire

// ---- test/idle_power_gate_bench.sv ----
// Bench for idle_power_gate: APB register tests and idle entry and wake.
// Assumes the design header on the include path and the oscillator model.
`timescale 1ns/100ps
`default_nettype none
`include "power_gate_cfg.svh"
module idle_power_gate_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic sleep_exec = 1'b0;
   logic irq_wake = 1'b0;
   logic wdt_timeout = 1'b0;
   logic [7:0] osc_start = 8'h02;
   wire logic pready, pslverr, cpu_clk_en, periph_clk_en, t1_pin;
   wire logic primary_osc_on, timer1_osc_on, internal_rc_on;
   wire logic [31:0] prdata, module_power_on;
   wire logic [1:0] periph_src;
   logic [7:0] masks [4];
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int n_compared = 0;

   idle_power_gate uut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sleep_exec(sleep_exec), .irq_wake(irq_wake),
      .wdt_timeout(wdt_timeout), .timer1_osc_ok_pin(t1_pin), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .periph_src(periph_src),
      .primary_osc_on(primary_osc_on), .timer1_osc_on(timer1_osc_on),
      .internal_rc_on(internal_rc_on), .module_power_on(module_power_on));
   t1_osc_model osc (.clk(clk), .enable(timer1_osc_on), .start_cycles(osc_start),
      .ok_pin(t1_pin));

   // ==========================================
   // Clock and shared tasks
   always #20 clk = ~clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; waits an edge first so strobes never change twice in a step
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(32'(n < 20), 32'h1, "pready wait");
   endtask

   task automatic wr(input logic [11:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask

   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      check(rd, exp, $sformatf("read %h", addr));
      check(32'(err), 32'h0, "slave error");
   endtask

   // 0 sleep, 1 interrupt, 2 watchdog: one-cycle pulse
   task automatic pulse(input int which);
      @(posedge clk);
      case (which)
         0: sleep_exec <= 1'b1;
         1: irq_wake <= 1'b1;
         default: wdt_timeout <= 1'b1;
      endcase
      @(posedge clk);
      sleep_exec <= 1'b0;
      irq_wake <= 1'b0;
      wdt_timeout <= 1'b0;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Wake event, then the CPU must stay stopped through the ready delay
   task automatic wake(input int which);
      int n;
      pulse(which);
      for (int i = 0; i < `WAKE_DELAY_CYCLES; i++) begin
         wait_n(1);
         check(32'(cpu_clk_en), 32'h0, "cpu held in wake delay");
      end
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 20) begin
         wait_n(1);
         n++;
      end
      check(32'(cpu_clk_en), 32'h1, "cpu resumed");
   endtask

   task automatic close_out;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      int n;
      masks = '{`MASK_CAPTURE_OFF, `MASK_TIMER_CMP_OFF,
         `MASK_TIMER_MISC_OFF & ~(8'h01 << `RTC_OFF_BIT), `MASK_SERIAL_OFF};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_n(1);
      check(module_power_on, 32'hFFFF_FFFF, "power after reset");
      for (int i = 0; i < 4; i++) rdchk(12'(4 * i), 32'h0);
      // Off bits: masks, locked real-time clock bit, power outputs
      for (int i = 0; i < 4; i++) wr(12'(4 * i), 32'h0000_00FF);
      for (int i = 0; i < 4; i++) rdchk(12'(4 * i), 32'(masks[i]));
      wait_n(2);
      check(module_power_on, ~{masks[0], masks[1], masks[2], masks[3]}, "power");
      wr(`OFF_UNLOCK_KEY, 32'h0000_0055);
      wr(`OFF_UNLOCK_KEY, 32'h0000_00AA);
      wr(`OFF_TIMER_MISC_OFF, 32'h0000_00FF);
      rdchk(`OFF_TIMER_MISC_OFF, 32'(`MASK_TIMER_MISC_OFF));
      rdchk(`OFF_UNLOCK_KEY, 32'h0);
      apb(1'b0, 12'h01C, 32'h0);
      check(32'(err), 32'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      // Refused sleeps: idle clear, or secondary without Timer1
      pulse(0);
      wait_n(3);
      check(32'(cpu_clk_en), 32'h1, "sleep without idle");
      wr(`OFF_CLOCK_CTRL, 32'h0000_0005);
      pulse(0);
      wait_n(3);
      check(32'(cpu_clk_en), 32'h1, "secondary without Timer1");
      // Primary idle, Timer1 running, watchdog disabled
      wr(`OFF_CLOCK_CTRL, 32'h0000_000C);
      wait_n(10);
      rdchk(`OFF_CLOCK_STATUS, 32'h0000_000D);
      pulse(0);
      wait_n(3);
      check({29'h0, cpu_clk_en, periph_clk_en, primary_osc_on}, 32'h3, "primary_clock_idle_mode");
      check({30'h0, periph_src}, 32'h0, "pri source");
      check(32'(timer1_osc_on), 32'h1, "Timer1 kept");
      rdchk(`OFF_CLOCK_STATUS, 32'h0000_0005);
      pulse(2);
      wait_n(8);
      check(32'(cpu_clk_en), 32'h0, "disabled watchdog woke");
      wake(1);
      check({29'h0, periph_src, primary_osc_on}, 32'h1, "pri resume");
      rdchk(`OFF_CLOCK_CTRL, 32'h0000_000C);
      rdchk(`OFF_CLOCK_STATUS, 32'h0000_000D);
      // Secondary idle with a slow Timer1 start, woken by the watchdog
      wr(`OFF_CLOCK_CTRL, 32'h0);
      osc_start <= 8'd40;
      wr(`OFF_CLOCK_CTRL, 32'h0000_001C);
      wr(`OFF_CLOCK_CTRL, 32'h0000_001D);
      pulse(0);
      wait_n(3);
      check({30'h0, cpu_clk_en, periph_clk_en}, 32'h0, "clocks withheld");
      check({29'h0, timer1_osc_on, internal_rc_on, primary_osc_on}, 32'h6, "osc");
      n = 0;
      while (periph_clk_en !== 1'b1 && n < 80) begin
         wait_n(1);
         n++;
      end
      check(32'(periph_clk_en), 32'h1, "clocks after start");
      check({30'h0, periph_src}, 32'h1, "sec source");
      rdchk(`OFF_CLOCK_STATUS, 32'h0000_0006);
      wake(2);
      check({29'h0, periph_src, timer1_osc_on}, 32'h3, "sec resume");
      rdchk(`OFF_CLOCK_CTRL, 32'h0000_001D);
      // Internal_osc_idle_mode: internal oscillator feeds peripherals, Timer1 and primary stop
      wr(`OFF_CLOCK_CTRL, 32'h0000_0006);
      pulse(0);
      wait_n(3);
      check({27'h0, cpu_clk_en, periph_clk_en, internal_rc_on, primary_osc_on, timer1_osc_on},
         32'hC, "internal_osc_idle_mode");
      check({30'h0, periph_src}, 32'h2, "rc source");
      wake(1);
      check({30'h0, periph_src}, 32'h2, "rc resume");
      // Mid-run reset: off bits set earlier must all clear again
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_n(1);
      check(module_power_on, 32'hFFFF_FFFF, "power after second reset");
      for (int i = 0; i < 4; i++) rdchk(12'(4 * i), 32'h0);
      close_out;
   end

   // ==========================================
   // Watchdog against a hang
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      $display("MISMATCH at %0t: run did not finish", $time);
      close_out;
   end
endmodule // idle_power_gate_bench
`default_nettype wire
